// [twm_pkg.sv]
// Shared constants, carriers and state codes of the two-wire master byte engine
package twm_pkg;

  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int          TWM_BYTE_W     = 8;
  localparam int          TWM_FIFO_DEPTH = 8;
  localparam int          TWM_CNT_W      = 9;
  localparam logic [3:0]  TWM_LAST_BIT   = 4'h8;
  localparam logic [8:0]  TWM_CNT_RST    = 9'h000;

  // ---------------------------------------------------------------
  // Operating-mode select code for two-wire operation
  // ---------------------------------------------------------------
  localparam logic [1:0]  TWM_MODE_TWOWIRE = 2'h2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Bus status word, bit 7 down to bit 0
  typedef struct packed {
    logic address_phase_event;
    logic byte_done_event;
    logic stop_done;
    logic arbitration_lost_flag;
    logic ack_received_flag;
    logic slave_selected;
    logic rx_mode;
    logic busy;
  } twm_status_t;

  localparam twm_status_t TWM_STATUS_RST = 8'h00;

  // Clock-line low/high periods and data hold, in system clocks
  typedef struct packed {
    logic [7:0] clk_low_period_reg;
    logic [7:0] clk_high_period_reg;
    logic [7:0] data_hold_reg;
  } twm_timing_t;

  // ---------------------------------------------------------------
  // Engine states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TWM_IDLE    = 4'b0000,
    TWM_START   = 4'b0001,
    TWM_LOW     = 4'b0010,
    TWM_HIGH    = 4'b0011,
    TWM_HOLD    = 4'b0100,
    TWM_FEED    = 4'b0101,
    TWM_RSTART  = 4'b0110,
    TWM_RS_HIGH = 4'b0111,
    TWM_STOP    = 4'b1000,
    TWM_STOP_H  = 4'b1001,
    TWM_STOP_E  = 4'b1010,
    TWM_SLV     = 4'b1011,
    TWM_SLV_ACK = 4'b1100,
    TWM_DONE    = 4'b1101
  } twm_state_t;

endpackage

// [twm_engine.sv]
// Two-wire master byte engine with its transmit byte FIFO
//
// How it works
// - Every handled bus event raises the interrupt, except a finished START or a lost arbitration without own-address match.
// - Interrupt sets the flag; any status write clears it.
// - Clock line stays low while the interrupt is pending, except for the stop interrupt.
// - Status word describes the bus state while the flag is set.
// - Four roles exist; the winning master decides which applies.
// - Two-wire mode code plus enable bit activates the engine.
// - Data byte carries address and payload; address bit 0 is direction.
// - Clock low and high times come from the period settings.
// - Data line changes a programmed delay after each clock fall.
// - Start command sends START then shifts out the data byte.
// - Address acknowledge is sampled in the ninth clock high.
// - Mastership kept after address: interrupt regardless of ack, clock held.
// - Arbitration loss sets the flag; matching address with ack enabled continues as slave.
// - Arbitration runs through data bytes; loss sets flag and idles.
// - Finished byte raises byte interrupt and holds the clock low.
// - Stop command before release makes STOP, then a stop interrupt.
// - New address with start command before release makes repeated START.
// - Direction bit after repeated START picks receiver or transmitter.
// - Ack enable decides whether a received byte is acknowledged.
// - Received-ack flag reports whether the remote acknowledged.
// - After STOP, status flags end; a write clears status and idles.
// - Hold delay equals hold setting times system clock period; the engine changes the data line one system clock later than that.
// - START is data falling with clock high; STOP is data rising.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Byte FIFO
// ---------------------------------------------------------------
module twm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,     // System clock
  input  wire logic             rst_i,     // Synchronous reset
  input  wire logic             clr_i,     // Flush contents
  input  wire logic             in_valid_i, // Write request
  input  wire logic [WIDTH-1:0] in_data_i, // Write data
  output logic                  in_ready_o, // Room available
  output logic                  out_valid_i_unused_o, // Word available
  output logic      [WIDTH-1:0] out_data_o, // Head word
  input  wire logic             out_ready_i // Head taken
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshakes and head word
  assign in_ready_o           = (count != (AW+1)'(DEPTH));
  assign out_valid_i_unused_o = (count != '0);
  assign out_data_o           = mem[rd_ptr];
  assign push                 = in_valid_i && in_ready_o;
  assign pop                  = out_ready_i && out_valid_i_unused_o;

  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // Pointers and fill level
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---------------------------------------------------------------
// Engine
// ---------------------------------------------------------------
module twm_engine #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic               clk_i,             // System clock, 125 MHz
  input  wire logic               rst_i,             // Synchronous reset
  input  wire logic [1:0]         unit_op_select_i,  // Operating-mode select
  input  wire logic               unit_enable_bit_i, // Unit enable
  input  wire twm_pkg::twm_timing_t timing_i,        // Periods and hold
  input  wire logic [6:0]         own_address_field_i, // Own slave address
  input  wire logic               ack_enable_bit_i,  // Acknowledge enable
  input  wire logic               start_cmd_i,       // Start command pulse
  input  wire logic               stop_cmd_i,        // Stop command pulse
  input  wire logic               status_wr_i,       // Status write pulse
  input  wire logic               tx_valid_i,        // Data byte offered
  input  wire logic [7:0]         tx_data_i,         // Data byte
  output logic                    tx_ready_o,        // FIFO has room
  output logic [7:0]              rx_data_o,         // Received byte
  output logic                    rx_valid_o,        // Received byte pulse
  output logic                    twowire_irq_flag_o, // Interrupt flag
  output twm_pkg::twm_status_t    bus_status_o,      // Bus status word
  input  wire logic               clock_line_i,      // Clock line level
  output logic                    clock_line_o,      // Clock line value
  output logic                    clock_line_oe_o,   // Clock line pulled low
  input  wire logic               data_line_i,       // Data line level
  output logic                    data_line_o,       // Data line value
  output logic                    data_line_oe_o     // Data line pulled low
);
  import twm_pkg::*;

  twm_state_t           state;
  twm_status_t          st;
  logic [TWM_CNT_W-1:0] cnt;
  logic [3:0]           bitn;
  logic [7:0]           sh;
  logic [7:0]           rxsh;
  logic                 addr_ph;
  logic                 rx_dir;
  logic                 scl_drv;
  logic                 sda_drv;
  logic                 irq;
  logic                 start_pend;
  logic                 stop_pend;
  logic                 act;
  logic [2:0]           scl_sync;
  logic [2:0]           sda_sync;
  logic                 scl_lvl;
  logic                 sda_lvl;
  logic                 scl_prev;
  logic                 f_valid;
  logic [7:0]           f_data;
  logic                 pop;
  logic                 tx_bit;
  logic                 drv_bit;
  logic                 low_done;
  logic                 high_done;
  logic                 hold_hit;

  assign act = (unit_op_select_i == TWM_MODE_TWOWIRE) && unit_enable_bit_i;

  // Open-drain pins: only ever pull low
  assign clock_line_o       = 1'b0;
  assign data_line_o        = 1'b0;
  assign clock_line_oe_o    = scl_drv;
  assign data_line_oe_o     = sda_drv;
  assign twowire_irq_flag_o = irq;
  assign bus_status_o       = st;

  // Transmit byte buffer
  twm_fifo #(
    .WIDTH (TWM_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .clr_i                (!act),
    .in_valid_i           (tx_valid_i),
    .in_data_i            (tx_data_i),
    .in_ready_o           (tx_ready_o),
    .out_valid_i_unused_o (f_valid),
    .out_data_o           (f_data),
    .out_ready_i          (pop)
  );

  // Line synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_lvl  <= 1'b1;
      sda_lvl  <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], clock_line_i};
      sda_sync <= {sda_sync[1:0], data_line_i};
      if (scl_sync[1] == scl_sync[2])
        scl_lvl <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_lvl <= sda_sync[2];
    end
  end

  // Bit timing and the bit to drive
  always_comb
  begin
    tx_bit    = addr_ph || !rx_dir;
    drv_bit   = (bitn < TWM_LAST_BIT) ? (tx_bit && !sh[7])
                                      : (!tx_bit && ack_enable_bit_i);
    hold_hit  = (cnt == {1'b0, timing_i.data_hold_reg});
    low_done  = (cnt >= {1'b0, timing_i.clk_low_period_reg})
                && (cnt > {1'b0, timing_i.data_hold_reg});
    high_done = scl_lvl && (cnt >= {1'b0, timing_i.clk_high_period_reg});
  end

  // FIFO head taken on a new START or a data byte going out
  always_comb
  begin
    case (state)
      TWM_IDLE:    pop = start_pend && f_valid && scl_lvl && sda_lvl;
      TWM_RS_HIGH: pop = high_done && f_valid;
      TWM_FEED:    pop = f_valid;
      default:     pop = 1'b0;
    endcase
  end

  // Command bits; a new command wins over its consumption
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !act)
    begin
      start_pend <= 1'b0;
      stop_pend  <= 1'b0;
    end
    else
    begin
      start_pend <= start_cmd_i || (start_pend && !(pop &&
                    (state == TWM_IDLE || state == TWM_RS_HIGH)));
      stop_pend  <= stop_cmd_i || (stop_pend &&
                    !(state == TWM_HOLD && status_wr_i));
    end
  end

  // Bus engine, status and interrupt flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !act)
    begin
      state     <= TWM_IDLE;
      st        <= TWM_STATUS_RST;
      cnt       <= TWM_CNT_RST;
      bitn      <= 4'h0;
      sh        <= 8'h00;
      rxsh      <= 8'h00;
      addr_ph   <= 1'b0;
      rx_dir    <= 1'b0;
      scl_drv   <= 1'b0;
      sda_drv   <= 1'b0;
      irq       <= 1'b0;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      scl_prev  <= 1'b1;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      scl_prev   <= scl_lvl;
      // Status write clears the flag; later sets below win
      if (status_wr_i)
      begin
        irq                      <= 1'b0;
        st.address_phase_event   <= 1'b0;
        st.byte_done_event       <= 1'b0;
        st.arbitration_lost_flag <= 1'b0;
      end
      case (state)
        TWM_IDLE:
        begin
          scl_drv <= 1'b0;
          sda_drv <= 1'b0;
          if (pop)
          begin
            sh      <= f_data;
            rx_dir  <= f_data[0];
            addr_ph <= 1'b1;
            sda_drv <= 1'b1;
            cnt     <= TWM_CNT_RST;
            state   <= TWM_START;
          end
        end
        TWM_START:
        begin
          cnt <= cnt + 9'h001;
          if (cnt >= {1'b0, timing_i.clk_high_period_reg})
          begin
            scl_drv <= 1'b1;
            st.busy <= 1'b1;
            cnt     <= TWM_CNT_RST;
            bitn    <= 4'h0;
            state   <= TWM_LOW;
          end
        end
        TWM_LOW:
        begin
          cnt <= cnt + 9'h001;
          if (hold_hit)
            sda_drv <= drv_bit;
          if (low_done)
          begin
            scl_drv <= 1'b0;
            cnt     <= TWM_CNT_RST;
            state   <= TWM_HIGH;
          end
        end
        TWM_HIGH:
        begin
          if (scl_lvl)
            cnt <= cnt + 9'h001;
          if (high_done)
          begin
            cnt <= TWM_CNT_RST;
            if (bitn < TWM_LAST_BIT && tx_bit && !sda_drv && !sda_lvl)
            begin
              st.arbitration_lost_flag <= 1'b1;
              st.busy <= 1'b0;
              rxsh    <= {rxsh[6:0], sda_lvl};
              bitn    <= bitn + 4'h1;
              state   <= addr_ph ? TWM_SLV : TWM_IDLE;
            end
            else if (bitn < TWM_LAST_BIT)
            begin
              rxsh    <= {rxsh[6:0], sda_lvl};
              sh      <= {sh[6:0], 1'b0};
              bitn    <= bitn + 4'h1;
              scl_drv <= 1'b1;
              state   <= TWM_LOW;
            end
            else
            begin
              scl_drv    <= 1'b1;
              irq        <= 1'b1;
              st.rx_mode <= rx_dir;
              if (tx_bit)
                st.ack_received_flag <= !sda_lvl;
              if (addr_ph)
                st.address_phase_event <= 1'b1;
              else
                st.byte_done_event <= 1'b1;
              if (!addr_ph && rx_dir)
              begin
                rx_data_o  <= rxsh;
                rx_valid_o <= 1'b1;
              end
              state <= TWM_HOLD;
            end
          end
        end
        TWM_HOLD:
        begin
          if (status_wr_i)
          begin
            addr_ph <= 1'b0;
            bitn    <= 4'h0;
            cnt     <= TWM_CNT_RST;
            if (stop_pend)
              state <= TWM_STOP;
            else if (start_pend)
              state <= TWM_RSTART;
            else if (rx_dir)
              state <= TWM_LOW;
            else
              state <= TWM_FEED;
          end
        end
        TWM_FEED:
        begin
          if (f_valid)
          begin
            sh    <= f_data;
            state <= TWM_LOW;
          end
        end
        TWM_RSTART:
        begin
          cnt <= cnt + 9'h001;
          if (hold_hit)
            sda_drv <= 1'b0;
          if (low_done)
          begin
            scl_drv <= 1'b0;
            cnt     <= TWM_CNT_RST;
            state   <= TWM_RS_HIGH;
          end
        end
        TWM_RS_HIGH:
        begin
          if (scl_lvl && !high_done)
            cnt <= cnt + 9'h001;
          if (pop)
          begin
            sh      <= f_data;
            rx_dir  <= f_data[0];
            addr_ph <= 1'b1;
            sda_drv <= 1'b1;
            cnt     <= TWM_CNT_RST;
            state   <= TWM_START;
          end
        end
        TWM_STOP:
        begin
          cnt <= cnt + 9'h001;
          if (hold_hit)
            sda_drv <= 1'b1;
          if (low_done)
          begin
            scl_drv <= 1'b0;
            cnt     <= TWM_CNT_RST;
            state   <= TWM_STOP_H;
          end
        end
        TWM_STOP_H:
        begin
          if (scl_lvl)
            cnt <= cnt + 9'h001;
          if (high_done)
          begin
            sda_drv <= 1'b0;
            cnt     <= TWM_CNT_RST;
            state   <= TWM_STOP_E;
          end
        end
        TWM_STOP_E:
        begin
          cnt <= cnt + 9'h001;
          if (cnt >= {1'b0, timing_i.clk_high_period_reg})
          begin
            irq          <= 1'b1;
            st.stop_done <= 1'b1;
            st.busy      <= 1'b0;
            state        <= TWM_DONE;
          end
        end
        TWM_SLV:
        begin
          // Follow the winning master to the end of the address byte
          if (scl_lvl && !scl_prev && bitn < TWM_LAST_BIT)
          begin
            rxsh <= {rxsh[6:0], sda_lvl};
            bitn <= bitn + 4'h1;
          end
          if (!scl_lvl && scl_prev && bitn == TWM_LAST_BIT)
          begin
            if (ack_enable_bit_i && rxsh[7:1] == own_address_field_i)
            begin
              sda_drv <= 1'b1;
              state   <= TWM_SLV_ACK;
            end
            else
              state <= TWM_IDLE;
          end
        end
        TWM_SLV_ACK:
        begin
          if (!scl_lvl && scl_prev)
          begin
            scl_drv           <= 1'b1;
            sda_drv           <= 1'b0;
            irq               <= 1'b1;
            st.slave_selected <= 1'b1;
            state             <= TWM_DONE;
          end
        end
        TWM_DONE:
        begin
          if (status_wr_i)
          begin
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
            st      <= TWM_STATUS_RST;
            state   <= TWM_IDLE;
          end
        end
        default:
          state <= TWM_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// [twm_engine_checker.sv]
// Port checker of the two-wire master byte engine
`timescale 1ns/1ps
`default_nettype none
module twm_engine_checker (
  input wire logic                 clk_i,              // Clock
  input wire logic                 rst_i,              // Reset
  input wire logic [1:0]           unit_op_select_i,   // Mode
  input wire logic                 unit_enable_bit_i,  // Enable
  input wire twm_pkg::twm_timing_t timing_i,           // Timing
  input wire logic                 status_wr_i,        // Status write
  input wire logic                 twowire_irq_flag_o, // Irq flag
  input wire twm_pkg::twm_status_t bus_status_o,       // Status
  input wire logic                 clock_line_i,       // Clock level
  input wire logic                 clock_line_oe_o,    // Clock low
  input wire logic                 data_line_oe_o      // Data low
);
  import twm_pkg::*;
  logic [8:0] lo_n; // Cycles clock held low
  logic [8:0] hi_n; // Cycles clock released
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Phase counters, high one saturates over idle gaps
  always_ff @(posedge clk_i)
  begin
    lo_n <= (rst_i || !clock_line_oe_o || status_wr_i) ? 9'h000 : lo_n + 9'h001;
    hi_n <= (rst_i || clock_line_oe_o) ? 9'h000 : hi_n + {8'h00, hi_n != 9'h1ff};
  end
  // Event, stall and line timing checks
  property p_hold;
    twowire_irq_flag_o && !bus_status_o.stop_done && !status_wr_i |=> clock_line_oe_o;
  endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  property p_clr;
    twowire_irq_flag_o && status_wr_i |=> !twowire_irq_flag_o;
  endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared");
  property p_code;
    twowire_irq_flag_o |-> (bus_status_o[7:4] != 4'h0) || bus_status_o.slave_selected;
  endproperty
  a_code: assert property (p_code) else $error("irq without code");
  property p_start;
    $rose(data_line_oe_o) && !clock_line_oe_o |-> clock_line_i && !twowire_irq_flag_o;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_low;
    $fell(clock_line_oe_o) |-> lo_n >= {1'b0, timing_i.clk_low_period_reg}
      && lo_n <= {1'b0, timing_i.clk_low_period_reg} + 9'h002;
  endproperty
  a_low: assert property (p_low) else $error("low period");
  property p_high;
    $rose(clock_line_oe_o) |-> hi_n >= {1'b0, timing_i.clk_high_period_reg};
  endproperty
  a_high: assert property (p_high) else $error("high period");
  property p_dhold;
    $changed(data_line_oe_o) && clock_line_oe_o |-> lo_n + 9'h001 >= {1'b0, timing_i.data_hold_reg};
  endproperty
  a_dhold: assert property (p_dhold) else $error("data hold");
  property p_off;
    !unit_enable_bit_i || unit_op_select_i != TWM_MODE_TWOWIRE
      |=> !clock_line_oe_o && !data_line_oe_o && !twowire_irq_flag_o;
  endproperty
  a_off: assert property (p_off) else $error("active while off");
endmodule
bind twm_engine twm_engine_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .unit_op_select_i(unit_op_select_i),
  .unit_enable_bit_i(unit_enable_bit_i), .timing_i(timing_i), .status_wr_i(status_wr_i),
  .twowire_irq_flag_o(twowire_irq_flag_o), .bus_status_o(bus_status_o),
  .clock_line_i(clock_line_i), .clock_line_oe_o(clock_line_oe_o),
  .data_line_oe_o(data_line_oe_o)
);
`default_nettype wire

// [twm_bus_slave.sv]
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module twm_bus_slave #(
  parameter logic [6:0] ADDR = 7'h5a // Device address
) (
  input  wire logic       scl_i,     // Clock level
  input  wire logic       sda_i,     // Data level
  input  wire logic       stretch_i, // Slow mode
  output logic            scl_oe_o,  // Pull clock low
  output logic            sda_oe_o,  // Pull data low
  output logic      [7:0] wr_byte_o, // Last written byte
  output logic            mack_o     // Master ack seen
);
  logic [7:0] b;  // Shifter
  logic [7:0] d;  // Read data
  logic       e;  // Frame ended
  logic       rs; // Repeated start
  // One byte MSB first, cut short by START or STOP
  task automatic get_byte;
    e = 1'b0;
    for (int i = 0; i < 8 && !e; i++)
    begin
      @(posedge scl_i);
      b = {b[6:0], sda_i};
      @(negedge scl_i or sda_i);
      e = scl_i;
    end
  endtask
  // Ack, then stretch the clock when slow
  task automatic ack;
    sda_oe_o = 1'b1;
    @(negedge scl_i);
    sda_oe_o = 1'b0;
    if (stretch_i)
    begin
      scl_oe_o = 1'b1;
      #400;
      scl_oe_o = 1'b0;
    end
  endtask
  // Address match, then write or read bytes
  initial
  begin
    {scl_oe_o, sda_oe_o, mack_o, wr_byte_o} = 11'h000;
    forever
    begin
      @(negedge sda_i iff scl_i);
      rs = 1'b1;
      while (rs)
      begin
        rs = 1'b0;
        get_byte();
        if (!e && b[7:1] == ADDR && b[0])
        begin
          d = 8'ha5;
          sda_oe_o = 1'b1;
          @(negedge scl_i);
          mack_o = 1'b1;
          while (mack_o)
          begin
            for (int i = 7; i >= 0; i--)
            begin
              sda_oe_o = !d[i];
              @(negedge scl_i);
            end
            sda_oe_o = 1'b0;
            @(posedge scl_i);
            mack_o = !sda_i;
            @(negedge scl_i);
            d = d + 8'h01;
          end
        end
        else if (!e && b[7:1] == ADDR)
        begin
          ack();
          while (!e)
          begin
            get_byte();
            if (!e)
            begin
              wr_byte_o = b;
              ack();
            end
          end
          rs = !sda_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb_twm_engine.sv]
// Testbench of the two-wire master byte engine
`timescale 1ns/1ps
`default_nettype none
module tb_twm_engine;
  import twm_pkg::*;
  localparam twm_timing_t TIM = {8'h0a, 8'h06, 8'h04}; // Hold is 4 clocks of the 10-clock low period
  logic        clk_i, rst_i, en, ack_en, start_c, stop_c, wr_c, tx_valid, stretch;
  logic [1:0]  op_sel;
  logic [7:0]  tx_data, rx_data, wr_byte;
  logic        tx_ready, rx_valid, irq, scl_oe, sda_oe, s_scl_oe, s_sda_oe, mack;
  twm_status_t st;
  int          num_errors = 0;
  int          total_checks = 0;
  wire         scl = !(scl_oe || s_scl_oe); // Pulled up when released
  wire         sda = !(sda_oe || s_sda_oe);
  // Design and slave
  twm_engine DUT (
    .clk_i(clk_i), .rst_i(rst_i), .unit_op_select_i(op_sel), .unit_enable_bit_i(en),
    .timing_i(TIM), .own_address_field_i(7'h33), .ack_enable_bit_i(ack_en),
    .start_cmd_i(start_c), .stop_cmd_i(stop_c), .status_wr_i(wr_c),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .twowire_irq_flag_o(irq),
    .bus_status_o(st), .clock_line_i(scl), .clock_line_o(), .clock_line_oe_o(scl_oe),
    .data_line_i(sda), .data_line_o(), .data_line_oe_o(sda_oe)
  );
  twm_bus_slave #(.ADDR(7'h5a)) u_slave (
    .scl_i(scl), .sda_i(sda), .stretch_i(stretch), .scl_oe_o(s_scl_oe),
    .sda_oe_o(s_sda_oe), .wr_byte_o(wr_byte), .mack_o(mack)
  );
  // Clock
  always #4 clk_i = ~clk_i;
  // Verdict
  task automatic close_out;
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Command pulses first, status write one clock later
  task automatic cmd(input logic s, input logic p, input logic w);
    if (s || p)
    begin
      {start_c, stop_c} = {s, p};
      @(negedge clk_i);
      {start_c, stop_c} = 2'h0;
    end
    wr_c = w;
    @(negedge clk_i);
    wr_c = 1'b0;
  endtask
  // FIFO push, valid held between bytes
  task automatic push(input logic [7:0] v);
    tx_valid = 1'b1;
    tx_data = v;
    @(negedge clk_i);
  endtask
  // Bounded wait for the flag
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(8'(irq), 8'h01);
  endtask
  // Stop, then clear
  task automatic stop_seq;
    cmd(1'b0, 1'b1, 1'b1);
    wait_irq();
    chk({5'h00, st.stop_done, st.busy, scl_oe}, 8'h04);
    cmd(1'b0, 1'b0, 1'b1);
    chk(st, 8'h00);
  endtask
  // Tests
  initial
  begin
    clk_i = 1'b0;
    op_sel = 2'h0;
    tx_data = 8'h00;
    {rst_i, en, ack_en, start_c, stop_c, wr_c, tx_valid, stretch} = 8'h80;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    chk(st, 8'h00);
    chk({5'h00, irq, scl_oe, sda_oe}, 8'h00);
    // Wrong mode code leaves it off
    op_sel = 2'h1;
    en = 1'b1;
    push(8'hb4);
    tx_valid = 1'b0;
    cmd(1'b1, 1'b0, 1'b0);
    repeat (100) @(negedge clk_i);
    chk(8'(sda_oe), 8'h00);
    op_sel = TWM_MODE_TWOWIRE;
    // Fill FIFO, write seven bytes to a slow slave
    stretch = 1'b1;
    push(8'hb4);
    for (int i = 0; i < 7; i++)
      push(8'h10 + 8'(i));
    tx_valid = 1'b0;
    chk(8'(tx_ready), 8'h00);
    cmd(1'b1, 1'b0, 1'b0);
    wait_irq();
    chk(st, 8'h89);
    repeat (60) @(negedge clk_i);
    chk({6'h00, scl, scl_oe}, 8'h01);
    for (int i = 0; i < 7; i++)
    begin
      cmd(1'b0, 1'b0, 1'b1);
      chk(8'(irq), 8'h00);
      wait_irq();
      chk(st, 8'h49);
      chk(wr_byte, 8'h10 + 8'(i));
    end
    chk(8'(tx_ready), 8'h01);
    stop_seq();
    // Unanswered address, repeated START, two-byte read
    stretch = 1'b0;
    push(8'h22);
    tx_valid = 1'b0;
    cmd(1'b1, 1'b0, 1'b0);
    wait_irq();
    chk(st, 8'h81);
    push(8'hb5);
    tx_valid = 1'b0;
    cmd(1'b1, 1'b0, 1'b1);
    wait_irq();
    chk(st, 8'h8b);
    ack_en = 1'b1;
    cmd(1'b0, 1'b0, 1'b1);
    wait_irq();
    chk(8'(rx_valid), 8'h01);
    chk(rx_data, 8'ha5);
    chk(st, 8'h4b);
    chk(8'(mack), 8'h01);
    ack_en = 1'b0;
    cmd(1'b0, 1'b0, 1'b1);
    wait_irq();
    chk(rx_data, 8'ha6);
    chk(8'(mack), 8'h00);
    stop_seq();
    close_out();
  end
  // Watchdog
  initial
  begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
